// ### ptm_checker_properties.sv
// checker for step, table read and gpio masking timing
// assumes binding to ptm_prog_table, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module ptm_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic step_req,
  input wire logic step_ready,
  input wire logic jump_req,
  input wire logic [8:0] jump_addr,
  input wire logic [1:0] table_req_mode,
  input wire logic table_done,
  input wire logic [8:0] prog_counter,
  input wire logic emulation_variant,
  input wire logic debug_active,
  input wire logic pa0_gpio_in,
  input wire logic pa2_gpio_in
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic take;
  logic tbl;
  // accepted step, accepted table read
  assign take = step_req && step_ready;
  assign tbl = take && table_req_mode != 2'h0;
  chk_pc_reset: assert property ($rose(rst_b) |-> prog_counter == 9'h000) else $error("pc not at vector");
  chk_table_stall: assert property (tbl |=> !step_ready ##1 step_ready) else $error("stall length");
  chk_stall_cause: assert property (!step_ready |-> $past(tbl)) else $error("stray stall");
  chk_done_timing: assert property (tbl |-> ##2 table_done) else $error("done late");
  chk_done_pulse: assert property (table_done |=> !table_done) else $error("done too long");
  chk_pc_next: assert property (take && !jump_req |=>
    prog_counter == $past(prog_counter) + 9'h001) else $error("pc step");
  chk_pc_jump: assert property (take && jump_req |=> prog_counter == $past(jump_addr)) else $error("pc jump");
  chk_gpio_mask: assert property (emulation_variant && debug_active |->
    !pa0_gpio_in && !pa2_gpio_in) else $error("gpio seen");
  // main scenarios
  cover property (tbl ##1 !step_ready ##1 tbl);
  cover property (take && jump_req);
  cover property (emulation_variant && debug_active);
endmodule : ptm_checker
`default_nettype wire

// ### ptm_core_model.sv
// core model issuing steps, jumps and table reads
// assumes requests are sampled on the rising edge
`timescale 1ns/100ps
`default_nettype none
module ptm_core_model (
  input wire logic ref_clk,
  input wire logic step_ready,
  output logic step_req,
  output logic jump_req,
  output logic [8:0] jump_addr,
  output logic [1:0] table_req_mode,
  output logic [7:0] table_ptr,
  output logic [4:0] table_dest
);
  initial {step_req, jump_req, jump_addr, table_req_mode, table_ptr, table_dest} = '0;
  // drop the request while stalled, then hold one step for an edge
  task automatic issue(input logic j, input logic [8:0] a, input logic [1:0] m, input logic [7:0] p,
                       input logic [4:0] d);
    while (!step_ready) begin
      step_req = 1'b0;
      @(negedge ref_clk);
    end
    {step_req, jump_req, jump_addr, table_req_mode, table_ptr, table_dest} = {1'b1, j, a, m, p, d};
    @(negedge ref_clk);
  endtask : issue
  task automatic idle();
    step_req = 1'b0;
  endtask : idle
endmodule : ptm_core_model
`default_nettype wire

// ### ptm_data_mem.sv
// general-purpose and special-function data memory with protection
// assumes one write and one read port driven by the core each cycle
`timescale 1ns/100ps
`default_nettype none
module ptm_data_mem
  import ptm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] gpr_reg [PTM_GPR_WORDS];
  logic [7:0] sfr_reg [PTM_SFR_WORDS];

  // general-purpose bytes, all read/write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PTM_GPR_WORDS; i++) gpr_reg[i] <= PTM_GPR_RESET;
    end else if (wr_en && wr_addr >= PTM_GPR_FIRST) begin
      gpr_reg[wr_addr[3:0]] <= wr_data;
    end
  end

  // special-function bytes, protected ones ignore writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PTM_SFR_WORDS; i++) sfr_reg[i] <= PTM_SFR_RESET;
    end else if (wr_en && wr_addr <= PTM_SFR_LAST && PTM_SFR_USED[wr_addr[3:0]]
                 && !PTM_SFR_PROTECT[wr_addr[3:0]]) begin
      sfr_reg[wr_addr[3:0]] <= wr_data;
    end
  end

  // registered read, unused special locations give zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= PTM_ZERO_BYTE;
    end else if (rd_addr >= PTM_GPR_FIRST) begin
      rd_data <= gpr_reg[rd_addr[3:0]];
    end else if (PTM_SFR_USED[rd_addr[3:0]]) begin
      rd_data <= sfr_reg[rd_addr[3:0]];
    end else begin
      rd_data <= PTM_ZERO_BYTE;
    end
  end
endmodule : ptm_data_mem
`default_nettype wire

// ### ptm_pkg.sv
// package for the program/table memory map block
// assumes a single 250 MHz clock domain and no software-visible registers
package ptm_pkg;
  localparam int PTM_PROG_WORDS = 512;
  localparam int PTM_PROG_AW = 9;
  localparam int PTM_PROG_DW = 12;
  localparam int PTM_DATA_AW = 5;
  localparam int PTM_DATA_DW = 8;
  localparam logic [8:0] PTM_RESET_VECTOR = 9'h000;
  localparam logic [8:0] PTM_LAST_PAGE_BASE = 9'h100;
  localparam logic [4:0] PTM_SFR_LAST = 5'h0F;
  localparam logic [4:0] PTM_GPR_FIRST = 5'h10;
  localparam logic [4:0] PTM_GPR_LAST = 5'h1F;
  localparam int PTM_GPR_WORDS = 16;
  localparam int PTM_SFR_WORDS = 16;
  // special-function locations that program writes cannot change
  localparam logic [15:0] PTM_SFR_PROTECT = 16'h0000;
  // special-function locations that exist; others read as zero
  localparam logic [15:0] PTM_SFR_USED = 16'hFFFF;
  localparam logic [7:0] PTM_SFR_RESET = 8'h00;
  localparam logic [7:0] PTM_GPR_RESET = 8'h00;
  localparam logic [7:0] PTM_ZERO_BYTE = 8'h00;
  localparam int PTM_TABLE_CYCLES = 2;
  typedef enum logic [1:0] {PTM_TRD_NONE, PTM_TRD_CURRENT, PTM_TRD_LAST} ptm_trd_mode_t;
endpackage : ptm_pkg

// ### ptm_prog_table.sv
// program store, program counter, table read path and debug pin muxing
// assumes the core presents one instruction request per cycle when ready
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - program store 512 words of 12 bits
// - reset loads program counter with 000H
// - table pointer addresses a word within one 256-word page
// - table read copies low byte to data
// - upper program bits never reach table path
// - current-page read offsets from executing page
// - last-page read offsets from 100H
// - table read takes two instruction cycles
// - programming uses shared data pin, external clock
// - debug data pin two-way, clock input only
// - debug pins' other functions disabled on emulation
// - data memory 8 bits, special 00H-0FH
// - general memory 10H-1FH, sixteen bytes
// - general memory fully read/write
// - protected special locations ignore writes
// - unused special locations read zero
// - page is 256 words, low eight bits
module ptm_prog_table
  import ptm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic step_req,
  input wire logic jump_req,
  input wire logic [8:0] jump_addr,
  input wire logic [1:0] table_req_mode,
  input wire logic [7:0] table_ptr,
  input wire logic [4:0] table_dest,
  output logic step_ready,
  output logic [8:0] prog_counter,
  output logic [11:0] instr_word,
  output logic table_done,
  input wire logic data_wr_en,
  input wire logic [4:0] data_wr_addr,
  input wire logic [7:0] data_wr_data,
  input wire logic [4:0] data_rd_addr,
  output logic [7:0] data_rd_data,
  input wire logic store_wr_en,
  input wire logic [8:0] store_wr_addr,
  input wire logic [11:0] store_wr_data,
  input wire logic emulation_variant,
  input wire logic debug_active,
  input wire logic debug_serial_clock_pin,
  input wire logic debug_serial_data_in,
  input wire logic debug_data_drive,
  input wire logic debug_data_out,
  output logic debug_serial_data_out,
  output logic debug_serial_data_oe,
  output logic debug_serial_clock_seen,
  input wire logic prog_serial_clock_pin,
  input wire logic prog_serial_data_in,
  input wire logic prog_data_drive,
  input wire logic prog_data_out,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  output logic prog_serial_data_seen,
  output logic prog_serial_clock_seen,
  input wire logic pa0_gpio_out,
  input wire logic pa0_gpio_oe,
  input wire logic pa2_gpio_out,
  input wire logic pa2_gpio_oe,
  output logic pa0_gpio_in,
  output logic pa2_gpio_in
);
  typedef enum logic {PTM_ST_RUN, PTM_ST_TABLE} ptm_state_t;
  ptm_state_t state_reg;
  logic [11:0] store_mem [PTM_PROG_WORDS];
  logic [8:0] table_addr_reg;
  logic [4:0] dest_reg;
  logic tbl_wr;
  logic dm_wr_en;
  logic [4:0] dm_wr_addr;
  logic [7:0] dm_wr_data;
  logic [8:0] table_addr_next;
  logic step_take;
  logic tbl_start;
  logic debug_owns_pins;
  logic [7:0] tbl_low_byte;

  // last page: fixed base plus pointer; every other mode reads the current page
  // current page: page bit from the program counter, offset from pointer
  function automatic logic [8:0] ptm_table_addr(input logic [1:0] mode, input logic [8:0] pc,
                                                input logic [7:0] ptr);
    if (mode == PTM_TRD_LAST) ptm_table_addr = PTM_LAST_PAGE_BASE | {1'b0, ptr};
    else ptm_table_addr = {pc[8], ptr};
  endfunction : ptm_table_addr

  // handshake: the core stalls only in the second table cycle
  assign table_addr_next = ptm_table_addr(table_req_mode, prog_counter, table_ptr);
  assign step_ready = (state_reg == PTM_ST_RUN);
  assign step_take = step_req && step_ready;
  assign tbl_start = step_take && (table_req_mode != PTM_TRD_NONE);

  // program store, written only by the programming path
  always_ff @(posedge ref_clk) begin
    if (store_wr_en) begin
      store_mem[store_wr_addr] <= store_wr_data;
    end
  end

  // program counter: reset vector, step, jump
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_counter <= PTM_RESET_VECTOR;
    end else if (step_take) begin
      prog_counter <= jump_req ? jump_addr : prog_counter + 9'h001;
    end
  end

  // instruction fetch from the counter address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_word <= 12'h000;
    end else if (step_take) begin
      instr_word <= store_mem[prog_counter];
    end
  end

  // table read holds the core for one extra cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PTM_ST_RUN;
    end else begin
      unique case (state_reg)
        PTM_ST_RUN: begin
          if (tbl_start) begin
            state_reg <= PTM_ST_TABLE;
          end
        end
        PTM_ST_TABLE: begin
          state_reg <= PTM_ST_RUN;
        end
      endcase
    end
  end

  // table address and destination captured at the request edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      table_addr_reg <= 9'h000;
      dest_reg <= 5'h00;
    end else if (tbl_start) begin
      table_addr_reg <= table_addr_next;
      dest_reg <= table_dest;
    end
  end

  // second cycle writes the low byte to data memory
  assign tbl_wr = (state_reg == PTM_ST_TABLE);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      table_done <= 1'b0;
    end else begin
      table_done <= tbl_wr;
    end
  end

  // only the low byte of the addressed word leaves the store
  assign tbl_low_byte = store_mem[table_addr_reg][7:0];

  // table write takes the data port over the core's own write
  always_comb begin
    dm_wr_en = data_wr_en || tbl_wr;
    dm_wr_addr = tbl_wr ? dest_reg : data_wr_addr;
    dm_wr_data = tbl_wr ? tbl_low_byte : data_wr_data;
  end

  ptm_data_mem u_data_mem (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(dm_wr_en),
    .wr_addr(dm_wr_addr),
    .wr_data(dm_wr_data),
    .rd_addr(data_rd_addr),
    .rd_data(data_rd_data)
  );

  // programming data pin: programmer data while it drives, else pa0 output
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_serial_data_out <= 1'b0;
    end else begin
      prog_serial_data_out <= prog_data_drive ? prog_data_out : pa0_gpio_out;
    end
  end

  // debug data pin output register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_serial_data_out <= 1'b0;
    end else begin
      debug_serial_data_out <= debug_data_out;
    end
  end

  // the debug tool owns the shared pins only on the emulation variant
  assign debug_owns_pins = emulation_variant && debug_active;

  // programming pin group: shared data pin, clock from the programmer
  assign prog_serial_data_oe = prog_data_drive || (pa0_gpio_oe && !debug_owns_pins);
  assign prog_serial_data_seen = prog_serial_data_in;
  assign prog_serial_clock_seen = prog_serial_clock_pin;

  // debug pin group: data two-way, clock an input only
  assign debug_serial_data_oe = debug_owns_pins && debug_data_drive;
  assign debug_serial_clock_seen = debug_owns_pins && debug_serial_clock_pin;

  // gpio inputs read zero while the debug tool owns the pins
  assign pa0_gpio_in = debug_owns_pins ? 1'b0 : prog_serial_data_in;
  assign pa2_gpio_in = debug_owns_pins ? 1'b0 : prog_serial_clock_pin;

  // pa2 drive has no pin path here: both clock pins are inputs only
  // the spare inputs are folded together so they stay visibly unused
  logic pa2_unused;
  assign pa2_unused = pa2_gpio_out & pa2_gpio_oe & debug_serial_data_in;
endmodule : ptm_prog_table
`default_nettype wire

// ### tb.sv
// bench: program store, table reads, data memory
// assumes ptm_core_model on the step side
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ptm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic step_req, jump_req, step_ready, table_done, data_wr_en, store_wr_en;
  logic [1:0] table_req_mode;
  logic [4:0] table_dest, data_wr_addr, data_rd_addr;
  logic [7:0] table_ptr, data_wr_data, data_rd_data, exp_b;
  logic [8:0] jump_addr, prog_counter, store_wr_addr, exp_pc;
  logic [11:0] instr_word, store_wr_data;
  logic emulation_variant, debug_active, debug_serial_clock_pin, debug_serial_data_in, debug_data_drive;
  logic debug_data_out, prog_serial_clock_pin, prog_serial_data_in, prog_data_drive, prog_data_out;
  logic pa0_gpio_out, pa0_gpio_oe, pa2_gpio_out, pa2_gpio_oe, debug_serial_data_out, debug_serial_data_oe;
  logic debug_serial_clock_seen, prog_serial_data_out, prog_serial_data_oe, prog_serial_data_seen;
  logic prog_serial_clock_seen, pa0_gpio_in, pa2_gpio_in;
  logic [15:0] lf = 16'h26A6;
  logic [15:0] lp = 16'h26A6;
  logic [11:0] prog [512];
  logic [7:0] texp [32];
  int fails = 0;
  int comparisons = 0;
  ptm_prog_table i_dut (.*);
  ptm_core_model i_core (.*);
  // clock and random pin-side inputs
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) lp <= nx(lp);
  assign {emulation_variant, debug_active, debug_serial_clock_pin, debug_serial_data_in, debug_data_drive,
    debug_data_out, prog_serial_clock_pin, prog_serial_data_in, prog_data_drive, prog_data_out, pa0_gpio_out,
    pa0_gpio_oe, pa2_gpio_out, pa2_gpio_oe} = lp[13:0];
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  // pin-side outputs expected from the pin inputs now applied
  function automatic logic [8:0] pin_exp();
    logic dbg;
    dbg = emulation_variant && debug_active;
    return {prog_data_drive ? prog_data_out : pa0_gpio_out, debug_data_out,
      prog_data_drive || (pa0_gpio_oe && !dbg), dbg && debug_data_drive, prog_serial_data_in,
      prog_serial_clock_pin, dbg && debug_serial_clock_pin, !dbg && prog_serial_data_in, !dbg && prog_serial_clock_pin};
  endfunction : pin_exp
  task automatic cmp(input logic [20:0] got, input logic [20:0] want);
    comparisons++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : cmp
  task automatic close_out();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    data_rd_addr = a;
    @(negedge ref_clk);
    cmp(21'(data_rd_data), 21'(e));
  endtask : rd_chk
  // one step through the core; tracks pc and table results
  task automatic step(input logic j, input logic [8:0] a, input int m, input logic [7:0] p, input logic [4:0] d);
    logic [8:0] old;
    logic [8:0] pins;
    old = exp_pc;
    i_core.issue(j, a, 2'(m), p, d);
    exp_pc = j ? a : old + 9'h001;
    if (m == 1) texp[d] = prog[{old[8], p}][7:0];
    if (m == 2) texp[d] = prog[PTM_LAST_PAGE_BASE + 9'(p)][7:0];
    cmp({instr_word, prog_counter}, {prog[old], exp_pc});
    pins = {prog_serial_data_out, debug_serial_data_out, prog_serial_data_oe, debug_serial_data_oe,
      prog_serial_data_seen, prog_serial_clock_seen, debug_serial_clock_seen, pa0_gpio_in, pa2_gpio_in};
    cmp(21'(pins), 21'(pin_exp()));
  endtask : step
  initial begin
    #20000;
    fails++;
    close_out();
  end
  initial begin
    {data_wr_en, store_wr_en, data_wr_addr, data_wr_data, data_rd_addr, store_wr_addr, store_wr_data} = '0;
    exp_pc = PTM_RESET_VECTOR;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    cmp(21'(prog_counter), 21'(PTM_RESET_VECTOR));
    // random program store contents
    for (int i = 0; i < PTM_PROG_WORDS; i++) begin
      lf = nx(lf);
      prog[i] = lf[11:0];
      {store_wr_en, store_wr_addr, store_wr_data} = {1'b1, 9'(i), lf[11:0]};
      @(negedge ref_clk);
    end
    store_wr_en = 1'b0;
    // write then read every data address
    for (int a = 0; a < 32; a++) begin
      lf = nx(lf);
      {data_wr_en, data_wr_addr, data_wr_data} = {1'b1, 5'(a), lf[7:0]};
      @(negedge ref_clk);
      data_wr_en = 1'b0;
      exp_b = (a < 16 && PTM_SFR_PROTECT[a]) ? PTM_SFR_RESET : lf[7:0];
      if (a < 16 && !PTM_SFR_USED[a]) exp_b = PTM_ZERO_BYTE;
      rd_chk(5'(a), exp_b);
    end
    // jump, two back-to-back table reads, read both bytes
    for (int k = 0; k < 24; k++) begin
      lf = nx(lf);
      step(1'b1, (k < 2) ? {k[0], 8'hFF} : lf[8:0], 0, 8'h00, 5'h00);
      step(1'b0, 9'h000, k % 2 + 1, (k < 4) ? 8'hFF : lf[15:8], 5'h10);
      step(1'b0, 9'h000, 2 - k % 2, (k < 4) ? 8'h00 : lf[7:0], 5'h11);
      i_core.idle();
      @(negedge ref_clk);
      rd_chk(5'h10, texp[16]);
      rd_chk(5'h11, texp[17]);
    end
    // mid-run reset: counter back to the vector, data memory cleared
    rst_b = 1'b0;
    @(negedge ref_clk);
    rst_b = 1'b1;
    exp_pc = PTM_RESET_VECTOR;
    cmp(21'(prog_counter), 21'(PTM_RESET_VECTOR));
    step(1'b0, 9'h000, 0, 8'h00, 5'h00);
    i_core.idle();
    rd_chk(5'h10, PTM_GPR_RESET);
    close_out();
  end
endmodule : tb
bind ptm_prog_table ptm_checker i_chk (.*);
`default_nettype wire
